// ---- pkg/lmt_pkg.sv ----
// constants and carrier types for the legacy address/data match trigger
package lmt_pkg;

    // ==========================================================
    // geometry
    localparam int XLEN = 64;
    localparam int NUM_TRIG = 4;
    localparam int IDX_W = 2;

    // ==========================================================
    // register addresses
    localparam logic [11:0] ADDR_CONFIG = 12'h7a1;
    localparam logic [11:0] ADDR_COMPARE = 12'h7a2;

    // ==========================================================
    // field positions of the configuration word
    localparam int POS_TYPE_HI = 63;
    localparam int POS_TYPE_LO = 60;
    localparam int POS_DMODE = 59;
    localparam int POS_MASKMAX_HI = 58;
    localparam int POS_MASKMAX_LO = 53;
    localparam int POS_SIZEHI_HI = 22;
    localparam int POS_SIZEHI_LO = 21;
    localparam int POS_HIT = 20;
    localparam int POS_SELECT = 19;
    localparam int POS_TIMING = 18;
    localparam int POS_SIZELO_HI = 17;
    localparam int POS_SIZELO_LO = 16;
    localparam int POS_ACTION_HI = 15;
    localparam int POS_ACTION_LO = 12;
    localparam int POS_CHAIN = 11;
    localparam int POS_MATCH_HI = 10;
    localparam int POS_MATCH_LO = 7;
    localparam int POS_M = 6;
    localparam int POS_S = 4;
    localparam int POS_U = 3;
    localparam int POS_EXECUTE = 2;
    localparam int POS_STORE = 1;
    localparam int POS_LOAD = 0;

    // ==========================================================
    // preset and reset values
    localparam logic [3:0] TYPE_LEGACY = 4'h2;
    localparam logic [5:0] MASKMAX_VAL = 6'h06;
    localparam logic [XLEN-1:0] COMPARE_RESET = 64'h0000_0000_0000_0000;

    // ==========================================================
    // encodings
    localparam logic [3:0] MATCH_EQUAL = 4'h0;
    localparam logic [3:0] MATCH_NAPOT = 4'h1;
    localparam logic [3:0] MATCH_GE = 4'h2;
    localparam logic [3:0] MATCH_LT = 4'h3;
    localparam logic [3:0] ACTION_BREAK = 4'h0;
    localparam logic [3:0] ACTION_DEBUG = 4'h1;
    localparam logic [1:0] PRIV_U = 2'h0;
    localparam logic [1:0] PRIV_S = 2'h1;
    localparam logic [1:0] PRIV_M = 2'h3;
    localparam logic [3:0] SIZE_ANY = 4'h0;
    localparam logic [3:0] SIZE_8 = 4'h1;
    localparam logic [3:0] SIZE_16 = 4'h2;
    localparam logic [3:0] SIZE_32 = 4'h3;
    localparam logic [3:0] SIZE_64 = 4'h5;

    // ==========================================================
    // stored writable fields of one trigger
    typedef struct packed {
        logic [1:0] sizehi;
        logic hit;
        logic select;
        logic timing;
        logic [1:0] sizelo;
        logic [3:0] action;
        logic chain;
        logic [3:0] match;
        logic m;
        logic s;
        logic u;
        logic execute;
        logic store;
        logic load;
    } lmt_cfg_type;

    localparam lmt_cfg_type CFG_RESET = '0;

    // one operation presented by the pipeline
    typedef struct packed {
        logic valid;
        logic is_exec;
        logic is_load;
        logic is_store;
        logic [1:0] priv;
        logic [3:0] size;
        logic [XLEN-1:0] addr;
        logic [XLEN-1:0] data;
        logic [XLEN-1:0] pc;
        logic [XLEN-1:0] next_pc;
    } lmt_event_type;

endpackage

// ---- core/lmt_compare.sv ----
// match logic of one trigger against one pipeline operation
`timescale 1ns/100ps
`default_nettype none
module lmt_compare (
    input wire lmt_pkg::lmt_cfg_type cfg,               // trigger configuration
    input wire logic [lmt_pkg::XLEN-1:0] cmp_value,     // programmed compare value
    input wire lmt_pkg::lmt_event_type ev,              // operation under test
    input wire logic extra_ok,                          // extra conditions met
    output logic match                                  // trigger matches
);

    logic kind_ok;
    logic priv_ok;
    logic size_ok;
    logic [3:0] size_sel;
    logic [lmt_pkg::XLEN-1:0] data_mask;
    logic [lmt_pkg::XLEN-1:0] value;
    logic [lmt_pkg::XLEN-1:0] napot_ign;
    logic [lmt_pkg::XLEN-1:0] max_ign;
    logic val_ok;

    // operation kind and privilege filter
    assign kind_ok = (ev.is_exec & cfg.execute) | (ev.is_load & cfg.load) | (ev.is_store & cfg.store);
    assign priv_ok = (ev.priv == lmt_pkg::PRIV_M) ? cfg.m :
                     (ev.priv == lmt_pkg::PRIV_S) ? cfg.s :
                     (ev.priv == lmt_pkg::PRIV_U) ? cfg.u : 1'b0;

    // RQ11 - combined size field
    assign size_sel = {cfg.sizehi, cfg.sizelo};
    assign size_ok = (size_sel == lmt_pkg::SIZE_ANY) || (size_sel == ev.size);

    // data bits beyond the access size read as zero
    always_comb begin
        unique case (ev.size)
            lmt_pkg::SIZE_8: data_mask = 64'h0000_0000_0000_00ff;
            lmt_pkg::SIZE_16: data_mask = 64'h0000_0000_0000_ffff;
            lmt_pkg::SIZE_32: data_mask = 64'h0000_0000_ffff_ffff;
            default: data_mask = 64'hffff_ffff_ffff_ffff;
        endcase
    end

    // RQ14 - address mode lowest byte
    // RQ15 - data mode one value
    assign value = cfg.select ? (ev.data & data_mask) : ev.addr;

    // napot ignores trailing ones plus first zero, no match when that exceeds maskmax
    assign napot_ign = cmp_value ^ (cmp_value + 64'h0000_0000_0000_0001);
    assign max_ign = (64'h0000_0000_0000_0001 << lmt_pkg::MASKMAX_VAL) - 64'h0000_0000_0000_0001;

    // value comparison per match mode
    always_comb begin
        unique case (cfg.match)
            lmt_pkg::MATCH_EQUAL: val_ok = (value == cmp_value);
            lmt_pkg::MATCH_NAPOT: val_ok = ((napot_ign & ~max_ign) == '0) &&
                                           (((value ^ cmp_value) & ~napot_ign) == '0);
            lmt_pkg::MATCH_GE: val_ok = (value >= cmp_value);
            lmt_pkg::MATCH_LT: val_ok = (value < cmp_value);
            default: val_ok = 1'b0;
        endcase
    end

    // RQ8 - extra conditions gate
    assign match = ev.valid & kind_ok & priv_ok & size_ok & val_ok & extra_ok;

endmodule
`default_nettype wire

// ---- core/lmt_chain.sv ----
// resolution of chained trigger groups into per-trigger fire
`timescale 1ns/100ps
`default_nettype none
module lmt_chain (
    input wire logic [lmt_pkg::NUM_TRIG-1:0] match,     // raw match per trigger
    input wire logic [lmt_pkg::NUM_TRIG-1:0] chain,     // chain to next trigger
    input wire logic [lmt_pkg::NUM_TRIG-1:0] timing,    // timing per trigger
    output logic [lmt_pkg::NUM_TRIG-1:0] fire           // group fired, per member
);

    localparam int N = lmt_pkg::NUM_TRIG;

    logic [N-1:0] tail_ok;
    logic [N-1:0] head;
    logic [N-1:0] grp_fire;
    logic [N-1:0] before_fire;

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_link
            if (i == N - 1) begin : g_last
                assign tail_ok[i] = match[i];
            end else begin : g_mid
                // RQ4 - mixed timing never fires
                assign tail_ok[i] = match[i] & (~chain[i] | (tail_ok[i+1] & (timing[i] == timing[i+1])));
            end
            if (i == 0) begin : g_first
                assign head[i] = 1'b1;
                assign grp_fire[i] = tail_ok[i];
            end else begin : g_next
                assign head[i] = ~chain[i-1];
                assign grp_fire[i] = head[i] ? tail_ok[i] : grp_fire[i-1];
            end
        end
    endgenerate

    // RQ22 - before wins over after
    assign before_fire = grp_fire & ~timing;
    assign fire = (|before_fire) ? before_fire : grp_fire;

endmodule
`default_nettype wire

// ---- core/lmt_trigger.sv ----
// trigger module holding the legacy match triggers and their register access
`timescale 1ns/100ps
`default_nettype none
//
// Function
// RQ1 - configuration word shows this trigger only with type field reading 2, per index
// RQ2 - reset values apply to every implemented trigger, not just the selected one
// RQ3 - triggers may fire at any convenient pipeline point unless timing says
// RQ4 - a chain whose members differ in timing never fires
// RQ5 - load address triggers chainable with data support both timings
// RQ6 - breakpoint action reports the accessed address as faulting address
// RQ7 - chained group reports an address that fired any member
// RQ8 - extra condition inputs must hold for a match
// RQ9 - hit at bit 20, select at 19, timing at 18
// RQ10 - read-only preset maskmax gives log2 of largest napot range
// RQ11 - upper size bits exist for 64-bit, join lower size, reset zero
// RQ12 - hit sets on fire and stays writable by software
// RQ13 - an unimplemented hit would read zero and ignore writes
// RQ14 - address mode compares the lowest accessed virtual address
// RQ15 - data mode compares one value, masked to access size
// RQ16 - before timing acts pre-retire, return address is the matching instruction
// RQ17 - before data load trigger keeps the access but blocks writeback
// RQ18 - multi-access instruction may have any subset of accesses done
// RQ19 - after timing acts post-retire, return address is next instruction
// RQ20 - timing bit may be hard-wired or fully writable
// RQ21 - debugger tries timing 1 first for data load triggers
// RQ22 - a before match may suppress a simultaneous after match
// RQ23 - lower fields at their fixed bit positions
// RQ24 - select, timing, hit and upper size are legalised and reset to zero
module lmt_trigger (
    input wire logic core_clk,                                  // hart clock
    input wire logic rst_n,                                     // hart reset, active low
    input wire logic [11:0] csr_addr,                           // register address
    input wire logic csr_we,                                    // write strobe
    input wire logic csr_re,                                    // read strobe
    input wire logic [lmt_pkg::XLEN-1:0] csr_wdata,             // write data
    input wire logic [lmt_pkg::IDX_W-1:0] trig_index,           // selected trigger
    input wire lmt_pkg::lmt_event_type ev,                      // pipeline operation
    input wire logic [lmt_pkg::NUM_TRIG-1:0] extra_ok,          // extra conditions per trigger
    output logic [lmt_pkg::XLEN-1:0] csr_rdata_q,               // read data
    output logic csr_rvalid_q,                                  // read data valid
    output logic fire_q,                                        // a trigger fired
    output logic fire_before_q,                                 // fired trigger is before timed
    output logic [3:0] fire_action_q,                           // action to take
    output logic [lmt_pkg::XLEN-1:0] fire_tval_q,               // faulting virtual address
    output logic [lmt_pkg::XLEN-1:0] fire_epc_q,                // return address
    output logic suppress_wb_q,                                 // block load writeback
    output logic [lmt_pkg::NUM_TRIG-1:0] fired_vec_q            // which triggers fired
);

    localparam int N = lmt_pkg::NUM_TRIG;

    // ==========================================================
    // storage and decode

    lmt_pkg::lmt_cfg_type cfg_q [N];
    logic [lmt_pkg::XLEN-1:0] cmp_q [N];
    logic [N-1:0] match;
    logic [N-1:0] chain_vec;
    logic [N-1:0] timing_vec;
    logic [N-1:0] fire;
    logic any_fire;
    logic [lmt_pkg::IDX_W-1:0] first_idx;
    lmt_pkg::lmt_cfg_type first_cfg;
    logic wr_config;
    logic wr_compare;
    logic [lmt_pkg::XLEN-1:0] rd_word;

    assign wr_config = csr_we && (csr_addr == lmt_pkg::ADDR_CONFIG);
    assign wr_compare = csr_we && (csr_addr == lmt_pkg::ADDR_COMPARE);

    // ==========================================================
    // write legalisation

    // turn a raw written word into legal stored fields
    function automatic lmt_pkg::lmt_cfg_type legalise(input logic [lmt_pkg::XLEN-1:0] w, input logic last);
        lmt_pkg::lmt_cfg_type c;
        logic [3:0] mt;
        logic [3:0] ac;
        c = lmt_pkg::CFG_RESET;
        mt = w[lmt_pkg::POS_MATCH_HI:lmt_pkg::POS_MATCH_LO];
        ac = w[lmt_pkg::POS_ACTION_HI:lmt_pkg::POS_ACTION_LO];
        // RQ11 - upper size bits
        c.sizehi = w[lmt_pkg::POS_SIZEHI_HI:lmt_pkg::POS_SIZEHI_LO];
        // RQ9 - flag bit positions
        c.hit = w[lmt_pkg::POS_HIT];
        c.select = w[lmt_pkg::POS_SELECT];
        // RQ20 - timing fully writable
        c.timing = w[lmt_pkg::POS_TIMING];
        // RQ23 - lower field positions
        c.sizelo = w[lmt_pkg::POS_SIZELO_HI:lmt_pkg::POS_SIZELO_LO];
        c.action = (ac == lmt_pkg::ACTION_DEBUG) ? lmt_pkg::ACTION_DEBUG : lmt_pkg::ACTION_BREAK;
        c.chain = w[lmt_pkg::POS_CHAIN] & ~last;
        // RQ10 - napot only when maskmax nonzero
        if ((mt == lmt_pkg::MATCH_EQUAL) || (mt == lmt_pkg::MATCH_GE) || (mt == lmt_pkg::MATCH_LT) ||
            ((mt == lmt_pkg::MATCH_NAPOT) && (lmt_pkg::MASKMAX_VAL != 6'h00))) begin
            c.match = mt;
        end else begin
            c.match = lmt_pkg::MATCH_EQUAL;
        end
        c.m = w[lmt_pkg::POS_M];
        c.s = w[lmt_pkg::POS_S];
        c.u = w[lmt_pkg::POS_U];
        c.execute = w[lmt_pkg::POS_EXECUTE];
        c.store = w[lmt_pkg::POS_STORE];
        c.load = w[lmt_pkg::POS_LOAD];
        return c;
    endfunction

    // assemble the visible configuration word
    function automatic logic [lmt_pkg::XLEN-1:0] pack_word(input lmt_pkg::lmt_cfg_type c);
        logic [lmt_pkg::XLEN-1:0] w;
        w = '0;
        // RQ1 - type field reads legacy
        w[lmt_pkg::POS_TYPE_HI:lmt_pkg::POS_TYPE_LO] = lmt_pkg::TYPE_LEGACY;
        w[lmt_pkg::POS_DMODE] = 1'b0;
        // RQ10 - preset maskmax
        w[lmt_pkg::POS_MASKMAX_HI:lmt_pkg::POS_MASKMAX_LO] = lmt_pkg::MASKMAX_VAL;
        w[lmt_pkg::POS_SIZEHI_HI:lmt_pkg::POS_SIZEHI_LO] = c.sizehi;
        // RQ13 - hit is implemented, reads stored value
        w[lmt_pkg::POS_HIT] = c.hit;
        w[lmt_pkg::POS_SELECT] = c.select;
        w[lmt_pkg::POS_TIMING] = c.timing;
        w[lmt_pkg::POS_SIZELO_HI:lmt_pkg::POS_SIZELO_LO] = c.sizelo;
        w[lmt_pkg::POS_ACTION_HI:lmt_pkg::POS_ACTION_LO] = c.action;
        w[lmt_pkg::POS_CHAIN] = c.chain;
        w[lmt_pkg::POS_MATCH_HI:lmt_pkg::POS_MATCH_LO] = c.match;
        w[lmt_pkg::POS_M] = c.m;
        w[lmt_pkg::POS_S] = c.s;
        w[lmt_pkg::POS_U] = c.u;
        w[lmt_pkg::POS_EXECUTE] = c.execute;
        w[lmt_pkg::POS_STORE] = c.store;
        w[lmt_pkg::POS_LOAD] = c.load;
        return w;
    endfunction

    // ==========================================================
    // per-trigger state and matching

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_trig
            lmt_pkg::lmt_cfg_type wr_cfg;
            logic sel_me;

            assign sel_me = (int'(trig_index) == i);
            assign wr_cfg = legalise(csr_wdata, (i == N - 1));

            // configuration fields of this trigger
            // RQ2 - every trigger resets alike
            // RQ24 - warl fields reset zero
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    cfg_q[i] <= lmt_pkg::CFG_RESET;
                end else if (wr_config && sel_me) begin
                    cfg_q[i] <= wr_cfg;
                    // RQ12 - fire set wins over clear
                    cfg_q[i].hit <= wr_cfg.hit | fire[i];
                end else if (fire[i]) begin
                    cfg_q[i].hit <= 1'b1;
                end
            end

            // compare value of this trigger
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    cmp_q[i] <= lmt_pkg::COMPARE_RESET;
                end else if (wr_compare && sel_me) begin
                    cmp_q[i] <= csr_wdata;
                end
            end

            lmt_compare u_compare (
                .cfg(cfg_q[i]),
                .cmp_value(cmp_q[i]),
                .ev(ev),
                .extra_ok(extra_ok[i]),
                .match(match[i])
            );

            assign chain_vec[i] = cfg_q[i].chain;
            assign timing_vec[i] = cfg_q[i].timing;
        end
    endgenerate

    // ==========================================================
    // chain resolution

    lmt_chain u_chain (
        .match(match),
        .chain(chain_vec),
        .timing(timing_vec),
        .fire(fire)
    );

    assign any_fire = |fire;

    // lowest fired trigger decides action and timing
    always_comb begin
        first_idx = '0;
        for (int k = N - 1; k >= 0; k--) begin
            if (fire[k]) begin
                first_idx = k[lmt_pkg::IDX_W-1:0];
            end
        end
    end

    assign first_cfg = cfg_q[first_idx];

    // ==========================================================
    // action reporting

    // RQ3 - fire reported right after the operation
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fire_q <= 1'b0;
            fired_vec_q <= '0;
            fire_action_q <= lmt_pkg::ACTION_BREAK;
            fire_before_q <= 1'b0;
        end else begin
            fire_q <= any_fire;
            fired_vec_q <= fire;
            fire_action_q <= any_fire ? first_cfg.action : lmt_pkg::ACTION_BREAK;
            // RQ5 - both timings honoured
            fire_before_q <= any_fire & ~first_cfg.timing;
        end
    end

    // faulting address for breakpoint exceptions
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fire_tval_q <= '0;
        end else if (any_fire) begin
            // RQ6 - accessed address as tval
            // RQ7 - shared address for a group
            fire_tval_q <= (first_cfg.action == lmt_pkg::ACTION_BREAK) ? ev.addr : '0;
        end
    end

    // return address chosen by timing
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fire_epc_q <= '0;
        end else if (any_fire) begin
            if (!first_cfg.timing) begin
                // RQ16 - before returns to matching pc
                fire_epc_q <= ev.pc;
            end else begin
                // RQ19 - after returns to next pc
                fire_epc_q <= ev.next_pc;
            end
        end
    end

    // writeback block for before-timed data load triggers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            suppress_wb_q <= 1'b0;
        end else begin
            // RQ17 - access done, destination kept
            // RQ18 - no ordering of partial accesses
            suppress_wb_q <= any_fire & ~first_cfg.timing & first_cfg.select & ev.is_load;
        end
    end

    // ==========================================================
    // register read

    // read mux over the selected trigger
    always_comb begin
        unique case (csr_addr)
            lmt_pkg::ADDR_CONFIG: rd_word = pack_word(cfg_q[trig_index]);
            lmt_pkg::ADDR_COMPARE: rd_word = cmp_q[trig_index];
            default: rd_word = '0;
        endcase
    end

    // registered read answer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            csr_rdata_q <= '0;
            csr_rvalid_q <= 1'b0;
        end else begin
            csr_rvalid_q <= csr_re;
            csr_rdata_q <= csr_re ? rd_word : '0;
        end
    end

endmodule
`default_nettype wire

// ---- test/lmt_trigger_sva.sv ----
// checker for the legacy match trigger ports
`timescale 1ns/100ps
`default_nettype none
module lmt_trigger_sva (
    input wire logic core_clk, // hart clock
    input wire logic rst_n, // hart reset
    input wire logic [11:0] csr_addr, // register address
    input wire logic csr_re, // read strobe
    input wire lmt_pkg::lmt_event_type ev, // pipeline operation
    input wire logic [63:0] csr_rdata_q, // read data
    input wire logic csr_rvalid_q, // read valid
    input wire logic fire_q, // fired
    input wire logic fire_before_q, // before timed
    input wire logic [63:0] fire_tval_q, // faulting address
    input wire logic [63:0] fire_epc_q, // return address
    input wire logic suppress_wb_q, // writeback blocked
    input wire logic [3:0] fired_vec_q // fired triggers
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // assertions
    read_answer_a: assert property (csr_re |=> csr_rvalid_q)
        else $error("read not answered");
    rvalid_cause_a: assert property (csr_rvalid_q |-> $past(csr_re))
        else $error("read valid without read");
    idle_rdata_a: assert property (!csr_rvalid_q |-> csr_rdata_q == 64'h0)
        else $error("read data not zero when idle");
    type_field_a: assert property (csr_re && csr_addr == 12'h7a1 |=> csr_rdata_q[63:60] == 4'h2)
        else $error("type field not 2");
    maskmax_preset_a: assert property (csr_re && csr_addr == 12'h7a1 |=> csr_rdata_q[59:53] == 7'h06)
        else $error("maskmax preset wrong");
    valid_only_a: assert property (!ev.valid |=> !fire_q)
        else $error("fire without operation");
    fire_vector_a: assert property (fire_q == (fired_vec_q != 4'h0))
        else $error("fire and vector disagree");
    report_hold_a: assert property (!fire_q |-> $stable(fire_tval_q) && $stable(fire_epc_q))
        else $error("fault report moved without fire");
    suppress_cause_a: assert property (suppress_wb_q |-> fire_q && fire_before_q)
        else $error("writeback blocked without before fire");
    // main scenarios
    cover property (fire_q && fired_vec_q == 4'h3);
    cover property (suppress_wb_q);
    cover property (fire_q && !fire_before_q);
endmodule
bind lmt_trigger lmt_trigger_sva chk (.core_clk, .rst_n, .csr_addr, .csr_re, .ev, .csr_rdata_q, .csr_rvalid_q,
    .fire_q, .fire_before_q, .fire_tval_q, .fire_epc_q, .suppress_wb_q, .fired_vec_q);
`default_nettype wire

// ---- test/lmt_pipe_model.sv ----
// pipeline stand-in presenting one operation per call
`timescale 1ns/100ps
`default_nettype none
module lmt_pipe_model (
    input wire logic core_clk, // hart clock
    output var lmt_pkg::lmt_event_type ev // operation to the trigger block
);
    initial ev = '0;
    // ==========================================================
    // operation offered for one cycle
    task automatic issue(input lmt_pkg::lmt_event_type x);
        lmt_pkg::lmt_event_type y;
        ev = x;
        @(posedge core_clk);
        #1;
        y = ~x;
        y.valid = 1'b0;
        ev = y; // stale fields inverted, not held
    endtask
endmodule
`default_nettype wire

// ---- test/legacy_address_data_match_trigger_test.sv ----
// self-checking bench for the legacy match trigger
`timescale 1ns/100ps
`default_nettype none
module legacy_address_data_match_trigger_test;
    logic core_clk, rst_n, csr_we, csr_re, csr_rvalid_q, fire_q, fire_before_q, suppress_wb_q;
    logic [11:0] csr_addr;
    logic [63:0] csr_wdata, csr_rdata_q, fire_tval_q, fire_epc_q, ex;
    logic [1:0] trig_index;
    logic [3:0] extra_ok, fire_action_q, fired_vec_q;
    lmt_pkg::lmt_event_type ev;
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    lmt_trigger DUT (.core_clk, .rst_n, .csr_addr, .csr_we, .csr_re, .csr_wdata, .trig_index, .ev, .extra_ok,
        .csr_rdata_q, .csr_rvalid_q, .fire_q, .fire_before_q, .fire_action_q, .fire_tval_q, .fire_epc_q,
        .suppress_wb_q, .fired_vec_q);
    lmt_pipe_model PIPE (.core_clk, .ev);
    // ==========================================================
    // clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            close_out;
        end
    end
    // ==========================================================
    // tasks
    task chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [1:0] i, input logic [11:0] a, input logic [63:0] d);
        trig_index = i;
        csr_addr = a;
        csr_wdata = d;
        csr_we = 1'b1;
        @(posedge core_clk);
        #1;
        csr_we = 1'b0;
        @(posedge core_clk);
        #1;
    endtask
    task rd(input logic [1:0] i, input logic [11:0] a, input logic [63:0] exp);
        trig_index = i;
        csr_addr = a;
        csr_re = 1'b1;
        @(posedge core_clk);
        #1;
        csr_re = 1'b0;
        chk(csr_rdata_q, exp);
        @(posedge core_clk);
        #1;
    endtask
    task go(input lmt_pkg::lmt_event_type x, input logic [3:0] vec);
        PIPE.issue(x);
        chk(64'(fired_vec_q), 64'(vec));
    endtask
    function automatic logic [63:0] cw(input logic sel, input logic tim, input logic ch, input logic ld);
        cw = 64'h0000_0000_0000_0040; // machine mode enabled, action 0, match equal
        cw[19] = sel;
        cw[18] = tim;
        cw[11] = ch;
        cw[2] = !ld;
        cw[0] = ld;
    endfunction
    function automatic lmt_pkg::lmt_event_type mk(input logic ld, input logic [3:0] sz, input logic [63:0] d);
        mk = '0;
        mk.valid = 1'b1;
        mk.is_exec = !ld;
        mk.is_load = ld;
        mk.priv = 2'h3;
        mk.size = sz;
        mk.addr = ld ? 64'h2000 : 64'h1000;
        mk.data = d;
        mk.pc = 64'h8000;
        mk.next_pc = 64'h8004;
    endfunction
    task close_out;
        if (fails == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        {csr_we, csr_re, csr_addr, csr_wdata, trig_index} = '0;
        extra_ok = 4'hf;
        repeat (12) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        for (int i = 0; i < 4; i++) rd(2'(i), 12'h7a1, 64'h20c0_0000_0000_0000);
        rd(2'h0, 12'h7a2, 64'h0);
        wr(2'h1, 12'h7a1, 64'hf000_0000_007f_19ff);
        rd(2'h1, 12'h7a1, 64'h20c0_0000_007f_19df);
        rd(2'h1, 12'h7a0, 64'h0);
        wr(2'h1, 12'h7a1, 64'h0);
        wr(2'h0, 12'h7a2, 64'h1000);
        wr(2'h0, 12'h7a1, cw(0, 0, 0, 0));
        go(mk(0, 4'h0, 64'h0), 4'h1);
        chk(fire_tval_q, 64'h1000);
        chk(fire_epc_q, 64'h8000);
        chk(64'(fire_before_q), 64'h1);
        chk(64'(fire_action_q), 64'h0);
        rd(2'h0, 12'h7a1, 64'h20c0_0000_0010_0044);
        wr(2'h0, 12'h7a1, cw(0, 1, 0, 0));
        go(mk(0, 4'h0, 64'h0), 4'h1);
        chk(fire_epc_q, 64'h8004);
        chk(64'(fire_before_q), 64'h0);
        extra_ok = 4'he;
        go(mk(0, 4'h0, 64'h0), 4'h0);
        extra_ok = 4'hf;
        ex = 64'hffff_ffff_ffff_ff5a;
        wr(2'h0, 12'h7a2, 64'h5a);
        wr(2'h0, 12'h7a1, cw(1, 0, 0, 1));
        go(mk(1, 4'h2, ex), 4'h0);
        go(mk(1, 4'h1, ex), 4'h1);
        chk(64'(suppress_wb_q), 64'h1);
        chk(fire_tval_q, 64'h2000);
        wr(2'h0, 12'h7a2, 64'h1000);
        wr(2'h0, 12'h7a1, cw(0, 0, 1, 0));
        wr(2'h1, 12'h7a2, 64'h1000);
        wr(2'h1, 12'h7a1, cw(0, 1, 0, 0));
        go(mk(0, 4'h0, 64'h0), 4'h0);
        wr(2'h1, 12'h7a1, cw(0, 0, 0, 0));
        go(mk(0, 4'h0, 64'h0), 4'h3);
        chk(fire_tval_q, 64'h1000);
        wr(2'h0, 12'h7a1, cw(0, 0, 0, 0) | 64'h1000);
        go(mk(0, 4'h0, 64'h0), 4'h3);
        chk(64'(fire_action_q), 64'h1);
        chk(fire_tval_q, 64'h0);
        wr(2'h0, 12'h7a2, 64'h2007);
        wr(2'h0, 12'h7a1, cw(0, 0, 0, 1) | 64'h80);
        go(mk(1, 4'h2, 64'h0), 4'h1);
        wr(2'h0, 12'h7a1, cw(0, 0, 0, 1) | 64'h100);
        go(mk(1, 4'h2, 64'h0), 4'h0);
        wr(2'h0, 12'h7a1, cw(0, 0, 0, 1) | 64'h180);
        go(mk(1, 4'h2, 64'h0), 4'h1);
        close_out;
    end
endmodule
`default_nettype wire
